// File: hw/swdp_map.svh
// Constants of the single-wire debug port: offsets, fields, reset values, timing
`ifndef SWDP_MAP_SVH
`define SWDP_MAP_SVH

// APB register byte offsets
`define SWDP_APB_CTRL 12'h000
`define SWDP_APB_STATUS 12'h004
`define SWDP_APB_BAUD 12'h008
`define SWDP_APB_EVCNT 12'h00C

// Control register fields
`define SWDP_CTRL_PARITY_CHECK_DISABLE 0
`define SWDP_CTRL_OFF 1

// Status register fields
`define SWDP_ST_ACTIVE 0
`define SWDP_ST_HV 1
`define SWDP_ST_CLKSEL 2
`define SWDP_ST_ERR 4
`define SWDP_ST_BUSY 7

// Reset pin function fuse code that selects the port
`define SWDP_PINFUNC_PORT 2'h1

// Link clock select codes and oscillator rates in MHz
`define SWDP_CLKSEL_16M 2'h1
`define SWDP_CLKSEL_8M 2'h2
`define SWDP_CLKSEL_4M 2'h3
`define SWDP_CLKSEL_RST 2'h3
`define SWDP_OSC_MHZ_16 16
`define SWDP_OSC_MHZ_8 8
`define SWDP_OSC_MHZ_4 4
`define SWDP_CORE_MHZ 100

// Frame timing
`define SWDP_SAMPLES 16
`define SWDP_VOTE_FIRST 4'h7
`define SWDP_VOTE_LAST 4'h9
`define SWDP_BIT_LAST_SAMPLE 4'hF
`define SWDP_BREAK_BITS 12
`define SWDP_SYNC_LAST_FALL 3'h3
`define SWDP_SYNC_SHIFT 7
`define SWDP_FRAME_LAST_BIT 4'hB

// Frame bit indices
`define SWDP_BIT_START 4'h0
`define SWDP_BIT_PARITY 4'h9
`define SWDP_BIT_STOP1 4'hA

// Characters
`define SWDP_ACK_CHAR 8'h40

// Instruction opcodes in bits 7:5
`define SWDP_OP_BUS_RD 3'h0
`define SWDP_OP_BUS_WR 3'h2
`define SWDP_OP_SYS_LD 3'h4
`define SWDP_OP_SYS_ST 3'h6

// Direct system interface register indices
`define SWDP_SYS_CTRLA 4'h0
`define SWDP_SYS_STATUS 4'h1
`define SWDP_SYS_DBGCMD 4'h2
`define SWDP_SYS_BP0_LO 4'h3
`define SWDP_SYS_BP0_HI 4'h4
`define SWDP_SYS_BP1_LO 4'h5
`define SWDP_SYS_BP1_HI 4'h6
`define SWDP_SYS_BPEN 4'h7
`define SWDP_SYS_PC_LO 4'h8
`define SWDP_SYS_PC_HI 4'h9
`define SWDP_SYS_SP_LO 4'hA
`define SWDP_SYS_SP_HI 4'hB
`define SWDP_SYS_FLAGS 4'hC
`define SWDP_SYS_EVCNT 4'hD

// Error signature codes
`define SWDP_ERR_START 3'h1
`define SWDP_ERR_PARITY 3'h2
`define SWDP_ERR_STOP 3'h3
`define SWDP_ERR_ILLEGAL 3'h4

`endif

// File: hw/swdp_pkg.sv
// Types of the single-wire debug port
package swdp_pkg;

   typedef enum logic [3:0] {
      PH_OFF,
      PH_SYNC_WAIT,
      PH_SYNC,
      PH_RX_IDLE,
      PH_RX,
      PH_BUS,
      PH_TX,
      PH_ERR
   } swdp_phase_t;

   typedef struct packed {
      logic active;
      logic rst_func;
      logic hv;
      swdp_phase_t ph;
      logic [7:0] div_cnt;
      logic line_prev;
      logic [19:0] sync_cnt;
      logic [2:0] sync_falls;
      logic [12:0] samp_len;
      logic [12:0] samp_cnt;
      logic [3:0] sub;
      logic [3:0] bit_idx;
      logic [1:0] votes;
      logic [7:0] sh;
      logic [7:0] brk_cnt;
      logic [2:0] err_sig;
      logic [1:0] byte_n;
      logic [2:0] op;
      logic [3:0] sidx;
      logic [15:0] addr;
      logic [7:0] wdata;
      logic [11:0] tx_sh;
      logic xfer_req;
      logic bus_we;
      logic [1:0] clksel;
      logic [15:0] bp0;
      logic [15:0] bp1;
      logic [1:0] bp_en;
      logic [1:0] bp_hit;
      logic [3:0] dbg;
      logic [7:0] ev_cnt;
      logic parity_check_disable;
      logic off;
      logic [31:0] prdata;
      logic pslverr;
      logic rdy;
      logic pin_oe;
      logic pin_out;
   } swdp_state_t;

endpackage

// File: hw/swdp_top.sv
// Single-wire program and debug port: link layer, access layer, APB slave
//
// Contract
// - One shared wire, half duplex; only one party drives at a time.
// - Link layer runs from oscillator-rate tick; access layer on system clock.
// - Link-to-bus transfers pass a request/acknowledge boundary.
// - On enable, link clock select starts at the 4 MHz setting.
// - Link clock rate changes only by writing control register A, at reset or on enable; reset and enable restore the 4 MHz setting.
// - Port takes the pin when fuse selects it or high-voltage override seen.
// - While active, port drives pull-up, input and output enables itself.
// - Link layer keeps running in every sleep mode.
// - Bus accesses are withheld while the CPU clock is stopped.
// - Enable is accepted at any time, awake or asleep.
// - System interface reads debug, flags and status without bus requests.
// - Access layer masters the system bus for memory-mapped reads and writes.
// - Programming of memories and I/O space goes through bus writes.
// - Two hardware breakpoint comparators; software breakpoints need nothing here.
// - PC, stack pointer and flags readable while CPU runs.
// - Debugger commands run, halt, reset and step the CPU.
// - Link errors are detected and recorded as a readable signature.
// - Event pulses are counted to measure oscillator frequency.
// - CRC and sleep status readable without touching system registers.
// - Link timing derives from the link tick, not the CPU clock.
// - Frame: low start, eight data, even parity, two high stops; checked.
// - Twelve low bit times are a break and return port to default.
// - Sixteen samples per bit; value is majority of samples 7, 8, 9.
`timescale 1ns/1ps
`include "swdp_map.svh"

module swdp_top (
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic [1:0] i_reset_pin_function_fuse,
   input wire logic i_hv_override,
   input wire logic i_pin_in,
   output logic o_pin_out,
   output logic o_pin_oe,
   output logic o_pin_pullup_en,
   output logic o_pin_input_en,
   output logic o_pin_reset_func_en,
   output logic o_bus_req,
   output logic o_bus_we,
   output logic [15:0] o_bus_addr,
   output logic [7:0] o_bus_wdata,
   input wire logic i_bus_ack,
   input wire logic [7:0] i_bus_rdata,
   input wire logic i_cpu_clk_stopped,
   input wire logic [15:0] i_cpu_pc,
   input wire logic [15:0] i_cpu_sp,
   input wire logic [7:0] i_cpu_flags,
   input wire logic i_crc_status,
   input wire logic i_sleep_status,
   input wire logic i_osc_event,
   output logic o_cpu_run,
   output logic o_cpu_halt,
   output logic o_cpu_reset,
   output logic o_cpu_step,
   output logic [1:0] o_bp_hit
);

   localparam logic [7:0] BRK_SAMPLES = 8'(`SWDP_BREAK_BITS * `SWDP_SAMPLES);

   swdp_pkg::swdp_state_t q;
   swdp_pkg::swdp_state_t n;

   logic want_active;
   logic phy_tick;
   logic samp_tick;
   logic fall;
   logic in_vote;
   logic bit_v;
   logic ev_clr;
   logic [7:0] phy_div;
   logic [7:0] sys_rd;
   logic [12:0] meas_len;
   logic [1:0] hit;
   logic [31:0] bp_vec;

   // Link tick period in core cycles per oscillator setting
   always_comb begin
      case (q.clksel)
         `SWDP_CLKSEL_16M: phy_div = 8'(`SWDP_CORE_MHZ / `SWDP_OSC_MHZ_16);
         `SWDP_CLKSEL_8M: phy_div = 8'(`SWDP_CORE_MHZ / `SWDP_OSC_MHZ_8);
         default: phy_div = 8'(`SWDP_CORE_MHZ / `SWDP_OSC_MHZ_4);
      endcase
   end

   // Breakpoint comparators
   assign bp_vec = {q.bp1, q.bp0};
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_bp
         assign hit[g] = q.bp_en[g] & (i_cpu_pc == bp_vec[g*16 +: 16]);
      end
   endgenerate

   // System interface read mux, indexed by the low nibble of the instruction
   always_comb begin
      case (q.sh[3:0])
         `SWDP_SYS_CTRLA: sys_rd = {6'h00, q.clksel};
         `SWDP_SYS_STATUS: sys_rd = {3'h0, i_crc_status, i_sleep_status, q.err_sig};
         `SWDP_SYS_BP0_LO: sys_rd = q.bp0[7:0];
         `SWDP_SYS_BP0_HI: sys_rd = q.bp0[15:8];
         `SWDP_SYS_BP1_LO: sys_rd = q.bp1[7:0];
         `SWDP_SYS_BP1_HI: sys_rd = q.bp1[15:8];
         `SWDP_SYS_BPEN: sys_rd = {6'h00, q.bp_en};
         `SWDP_SYS_PC_LO: sys_rd = i_cpu_pc[7:0];
         `SWDP_SYS_PC_HI: sys_rd = i_cpu_pc[15:8];
         `SWDP_SYS_SP_LO: sys_rd = i_cpu_sp[7:0];
         `SWDP_SYS_SP_HI: sys_rd = i_cpu_sp[15:8];
         `SWDP_SYS_FLAGS: sys_rd = i_cpu_flags;
         `SWDP_SYS_EVCNT: sys_rd = q.ev_cnt;
         default: sys_rd = 8'h00;
      endcase
   end

   assign want_active = ((i_reset_pin_function_fuse == `SWDP_PINFUNC_PORT) | q.hv) & ~q.off;
   assign phy_tick = (q.div_cnt >= phy_div - 8'h01);
   assign samp_tick = phy_tick & (q.samp_cnt >= q.samp_len - 13'h0001);
   assign fall = q.line_prev & ~i_pin_in;
   assign in_vote = (q.sub >= `SWDP_VOTE_FIRST) & (q.sub <= `SWDP_VOTE_LAST);
   assign bit_v = q.votes[1];
   assign meas_len = (q.sync_cnt[19:`SWDP_SYNC_SHIFT] == 13'h0000) ? 13'h0001 :
                     q.sync_cnt[19:`SWDP_SYNC_SHIFT];

   // Start a transmit frame with the given byte
   function automatic logic [11:0] tx_frame(input logic [7:0] d);
      return {2'b11, ^d, d, 1'b0};
   endfunction

   always_comb begin
      n = q;
      ev_clr = 1'b0;
      n.dbg = 4'h0;
      n.bp_hit = hit;
      n.line_prev = i_pin_in;
      n.active = want_active;
      n.rst_func = ~want_active;
      n.rdy = 1'b1;
      if (i_hv_override) begin
         n.hv = 1'b1;
      end

      // APB slave: read data prepared in setup, writes at access
      if (i_psel & ~i_penable) begin
         n.pslverr = 1'b0;
         case (i_paddr)
            `SWDP_APB_CTRL: n.prdata = {30'h0, q.off, q.parity_check_disable};
            `SWDP_APB_STATUS: n.prdata = {24'h0, q.xfer_req, q.err_sig, q.clksel, q.hv, q.active};
            `SWDP_APB_BAUD: n.prdata = {19'h0, q.samp_len};
            `SWDP_APB_EVCNT: n.prdata = {24'h0, q.ev_cnt};
            default: begin
               n.prdata = 32'h0;
               n.pslverr = 1'b1;
            end
         endcase
      end
      if (i_psel & i_penable & i_pwrite & (i_paddr == `SWDP_APB_CTRL)) begin
         n.parity_check_disable = i_pwdata[`SWDP_CTRL_PARITY_CHECK_DISABLE];
         n.off = i_pwdata[`SWDP_CTRL_OFF];
      end

      // Link tick and sample timing
      n.div_cnt = phy_tick ? 8'h00 : q.div_cnt + 8'h01;
      if (samp_tick) begin
         n.samp_cnt = 13'h0000;
      end else if (phy_tick) begin
         n.samp_cnt = q.samp_cnt + 13'h0001;
      end

      case (q.ph)
         swdp_pkg::PH_OFF: begin
         end
         swdp_pkg::PH_SYNC_WAIT: begin
            if (fall) begin
               n.ph = swdp_pkg::PH_SYNC;
               n.sync_cnt = 20'h00000;
               n.sync_falls = 3'h0;
            end
         end
         swdp_pkg::PH_SYNC: begin
            if (phy_tick & (q.sync_cnt != 20'hFFFFF)) begin
               n.sync_cnt = q.sync_cnt + 20'h00001;
            end
            if (fall) begin
               n.sync_falls = q.sync_falls + 3'h1;
               if (q.sync_falls == `SWDP_SYNC_LAST_FALL) begin
                  n.samp_len = meas_len;
                  n.byte_n = 2'h0;
                  n.ph = swdp_pkg::PH_RX_IDLE;
               end
            end
         end
         swdp_pkg::PH_RX_IDLE: begin
            if (fall) begin
               n.ph = swdp_pkg::PH_RX;
               n.samp_cnt = 13'h0000;
               n.sub = 4'h0;
               n.bit_idx = 4'h0;
               n.votes = 2'h0;
            end
         end
         swdp_pkg::PH_RX: begin
            if (samp_tick) begin
               n.sub = q.sub + 4'h1;
               if (in_vote & i_pin_in) begin
                  n.votes = q.votes + 2'h1;
               end
               if (q.sub == `SWDP_BIT_LAST_SAMPLE) begin
                  n.votes = 2'h0;
                  n.bit_idx = q.bit_idx + 4'h1;
                  if (q.bit_idx == `SWDP_BIT_START) begin
                     if (bit_v) begin
                        n.err_sig = `SWDP_ERR_START;
                        n.ph = swdp_pkg::PH_ERR;
                     end
                  end else if (q.bit_idx < `SWDP_BIT_PARITY) begin
                     n.sh = {bit_v, q.sh[7:1]};
                  end else if (q.bit_idx == `SWDP_BIT_PARITY) begin
                     if (~q.parity_check_disable & (bit_v ^ (^q.sh))) begin
                        n.err_sig = `SWDP_ERR_PARITY;
                        n.ph = swdp_pkg::PH_ERR;
                     end
                  end else if (~bit_v) begin
                     n.err_sig = `SWDP_ERR_STOP;
                     n.ph = swdp_pkg::PH_ERR;
                  end else if (q.bit_idx == `SWDP_FRAME_LAST_BIT) begin
                     n.ph = swdp_pkg::PH_RX_IDLE;
                     n.byte_n = q.byte_n + 2'h1;
                     case (q.byte_n)
                        2'h0: begin
                           n.op = q.sh[7:5];
                           n.sidx = q.sh[3:0];
                           if (q.sh[7:5] == `SWDP_OP_SYS_LD) begin
                              n.tx_sh = tx_frame(sys_rd);
                              n.ph = swdp_pkg::PH_TX;
                           end else if ((q.sh[7:5] != `SWDP_OP_SYS_ST) & (q.sh[7:5] != `SWDP_OP_BUS_RD) &
                                        (q.sh[7:5] != `SWDP_OP_BUS_WR)) begin
                              n.err_sig = `SWDP_ERR_ILLEGAL;
                              n.ph = swdp_pkg::PH_ERR;
                           end
                        end
                        2'h1: begin
                           if (q.op == `SWDP_OP_SYS_ST) begin
                              case (q.sidx)
                                 `SWDP_SYS_CTRLA: n.clksel = q.sh[1:0];
                                 `SWDP_SYS_DBGCMD: n.dbg = q.sh[3:0];
                                 `SWDP_SYS_BP0_LO: n.bp0[7:0] = q.sh;
                                 `SWDP_SYS_BP0_HI: n.bp0[15:8] = q.sh;
                                 `SWDP_SYS_BP1_LO: n.bp1[7:0] = q.sh;
                                 `SWDP_SYS_BP1_HI: n.bp1[15:8] = q.sh;
                                 `SWDP_SYS_BPEN: n.bp_en = q.sh[1:0];
                                 `SWDP_SYS_EVCNT: ev_clr = 1'b1;
                                 default: begin
                                 end
                              endcase
                              n.tx_sh = tx_frame(`SWDP_ACK_CHAR);
                              n.ph = swdp_pkg::PH_TX;
                           end else begin
                              n.addr[7:0] = q.sh;
                           end
                        end
                        2'h2: begin
                           n.addr[15:8] = q.sh;
                           if (q.op == `SWDP_OP_BUS_RD) begin
                              n.bus_we = 1'b0;
                              n.ph = swdp_pkg::PH_BUS;
                           end
                        end
                        default: begin
                           n.wdata = q.sh;
                           n.bus_we = 1'b1;
                           n.ph = swdp_pkg::PH_BUS;
                        end
                     endcase
                     if (n.ph == swdp_pkg::PH_TX) begin
                        n.sub = 4'h0;
                        n.samp_cnt = 13'h0000;
                        n.bit_idx = 4'h0;
                     end
                  end
               end
            end
         end
         swdp_pkg::PH_BUS: begin
            // Request held until acknowledged; new request only while CPU clock runs
            n.xfer_req = q.xfer_req ? ~i_bus_ack : ~i_cpu_clk_stopped;
            if (q.xfer_req & i_bus_ack) begin
               n.tx_sh = tx_frame(q.bus_we ? `SWDP_ACK_CHAR : i_bus_rdata);
               n.ph = swdp_pkg::PH_TX;
               n.sub = 4'h0;
               n.samp_cnt = 13'h0000;
               n.bit_idx = 4'h0;
            end
         end
         swdp_pkg::PH_TX: begin
            n.pin_oe = 1'b1;
            n.pin_out = q.tx_sh[0];
            if (samp_tick) begin
               n.sub = q.sub + 4'h1;
               if (q.sub == `SWDP_BIT_LAST_SAMPLE) begin
                  n.tx_sh = {1'b1, q.tx_sh[11:1]};
                  n.pin_out = q.tx_sh[1];
                  n.bit_idx = q.bit_idx + 4'h1;
                  if (q.bit_idx == `SWDP_FRAME_LAST_BIT) begin
                     n.pin_oe = 1'b0;
                     n.pin_out = 1'b0;
                     n.ph = swdp_pkg::PH_SYNC_WAIT;
                  end
               end
            end
         end
         swdp_pkg::PH_ERR: begin
         end
         default: n.ph = swdp_pkg::PH_OFF;
      endcase

      // Break detection on the last stored baud
      if (samp_tick & (q.ph != swdp_pkg::PH_OFF) & (q.ph != swdp_pkg::PH_TX) & (q.ph != swdp_pkg::PH_BUS)) begin
         if (i_pin_in) begin
            n.brk_cnt = 8'h00;
         end else if (q.brk_cnt >= BRK_SAMPLES - 8'h01) begin
            n.brk_cnt = 8'h00;
            n.byte_n = 2'h0;
            n.ph = swdp_pkg::PH_SYNC_WAIT;
         end else begin
            n.brk_cnt = q.brk_cnt + 8'h01;
         end
      end

      // Event counter; a pulse in the clearing cycle is kept
      if (ev_clr) begin
         n.ev_cnt = {7'h00, i_osc_event};
      end else if (i_osc_event) begin
         n.ev_cnt = q.ev_cnt + 8'h01;
      end

      // Enable and disable of the port
      if (want_active & ~q.active) begin
         n.clksel = `SWDP_CLKSEL_RST;
         n.ph = swdp_pkg::PH_SYNC_WAIT;
         n.brk_cnt = 8'h00;
      end
      if (~want_active) begin
         n.ph = swdp_pkg::PH_OFF;
         n.pin_oe = 1'b0;
         n.pin_out = 1'b0;
         n.xfer_req = 1'b0;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         q <= '0;
         q.clksel <= `SWDP_CLKSEL_RST;
         q.rst_func <= 1'b1;
         q.rdy <= 1'b1;
         q.line_prev <= 1'b1;
         q.samp_len <= 13'h0001;
      end else begin
         q <= n;
      end
   end

   assign o_prdata = q.prdata;
   assign o_pready = q.rdy;
   assign o_pslverr = q.pslverr;
   assign o_pin_out = q.pin_out;
   assign o_pin_oe = q.pin_oe;
   assign o_pin_pullup_en = q.active;
   assign o_pin_input_en = q.active;
   assign o_pin_reset_func_en = q.rst_func;
   assign o_bus_req = q.xfer_req;
   assign o_bus_we = q.bus_we;
   assign o_bus_addr = q.addr;
   assign o_bus_wdata = q.wdata;
   assign o_cpu_run = q.dbg[0];
   assign o_cpu_halt = q.dbg[1];
   assign o_cpu_reset = q.dbg[2];
   assign o_cpu_step = q.dbg[3];
   assign o_bp_hit = q.bp_hit;

endmodule // swdp_top

// File: tb/swdp_top_asserts.sv
// Checker on the ports of the single-wire debug port
`timescale 1ns/1ps
`include "swdp_map.svh"

module swdp_top_asserts (
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic [1:0] i_reset_pin_function_fuse,
   input wire logic o_pin_out,
   input wire logic o_pin_oe,
   input wire logic o_pin_pullup_en,
   input wire logic o_pin_input_en,
   input wire logic o_pin_reset_func_en,
   input wire logic o_bus_req,
   input wire logic o_bus_we,
   input wire logic [15:0] o_bus_addr,
   input wire logic i_bus_ack,
   input wire logic i_cpu_clk_stopped,
   input wire logic o_cpu_halt
);
   localparam int TX_LO = 4770;
   localparam int TX_HI = 4830;
   logic [12:0] oe_cnt_q;

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);

   // Cycles of device drive on the wire
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         oe_cnt_q <= 13'h0000;
      end else begin
         oe_cnt_q <= o_pin_oe ? oe_cnt_q + 13'h0001 : 13'h0000;
      end
   end

   sequence s_ack_seen;
      o_bus_req && i_bus_ack;
   endsequence
   sequence s_reply_start;
      o_pin_oe && !o_pin_out;
   endsequence

   AST_REQ_HOLD: assert property (
      o_bus_req && !i_bus_ack |=> o_bus_req && $stable(o_bus_addr) && $stable(o_bus_we))
      else $error("Bus request changed before ack");
   AST_REQ_DROP: assert property (s_ack_seen |=> !o_bus_req)
      else $error("Bus request held after ack");
   AST_NO_REQ_STOPPED: assert property ($rose(o_bus_req) |-> !$past(i_cpu_clk_stopped))
      else $error("Bus request raised with cpu clock stopped");
   AST_REPLY_AFTER_ACK: assert property (s_ack_seen |-> ##[1:60] s_reply_start)
      else $error("No reply start after bus ack");
   AST_OE_LEN: assert property ($fell(o_pin_oe) |-> oe_cnt_q >= TX_LO && oe_cnt_q <= TX_HI)
      else $error("Reply frame length wrong");
   AST_STOP_LAST: assert property ($fell(o_pin_oe) |-> $past(o_pin_out))
      else $error("Wire released on a low bit");
   AST_PIN_OWNED: assert property (o_pin_reset_func_en |-> !o_pin_oe && !o_pin_pullup_en)
      else $error("Pin driven while in reset function");
   AST_PORT_PIN: assert property (
      i_reset_pin_function_fuse == `SWDP_PINFUNC_PORT |-> ##[1:2]
      (o_pin_pullup_en && o_pin_input_en && !o_pin_reset_func_en))
      else $error("Port did not take the pin");
   AST_HALT_PULSE: assert property (o_cpu_halt |=> !o_cpu_halt)
      else $error("Halt pulse longer than one cycle");
endmodule // swdp_top_asserts

bind swdp_top swdp_top_asserts i_swdp_top_asserts (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
   .i_reset_pin_function_fuse(i_reset_pin_function_fuse), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
   .o_pin_pullup_en(o_pin_pullup_en), .o_pin_input_en(o_pin_input_en),
   .o_pin_reset_func_en(o_pin_reset_func_en), .o_bus_req(o_bus_req), .o_bus_we(o_bus_we),
   .o_bus_addr(o_bus_addr), .i_bus_ack(i_bus_ack), .i_cpu_clk_stopped(i_cpu_clk_stopped),
   .o_cpu_halt(o_cpu_halt));

// File: tb/swdp_dbg_model.sv
// Debugger model: open-drain frames on the shared wire
`timescale 1ns/1ps

module swdp_dbg_model #(
   parameter int BIT_CYC = 400
) (
   input wire logic i_core_clk,
   input wire logic i_wire,
   output logic o_drv_low
);
   initial o_drv_low = 1'h0;

   task automatic send(input logic [7:0] d, input logic bad_par);
      logic [11:0] fr;
      fr = {2'h3, ^d ^ bad_par, d, 1'h0};
      // Half-bit idle before each frame
      repeat (BIT_CYC / 2) @(posedge i_core_clk);
      for (int i = 0; i < 12; i++) begin
         @(posedge i_core_clk);
         o_drv_low <= ~fr[i];
         repeat (BIT_CYC - 1) @(posedge i_core_clk);
      end
   endtask

   task automatic brk();
      @(posedge i_core_clk);
      o_drv_low <= 1'h1;
      repeat (13 * BIT_CYC) @(posedge i_core_clk);
      o_drv_low <= 1'h0;
      repeat (BIT_CYC) @(posedge i_core_clk);
   endtask

   task automatic recv(output logic [11:0] fr);
      int n;
      n = 0;
      fr = 12'hFFF;
      while (i_wire !== 1'h0 && n < 20000) begin
         @(posedge i_core_clk);
         n++;
      end
      repeat (BIT_CYC / 2) @(posedge i_core_clk);
      for (int i = 0; i < 12; i++) begin
         fr[i] = i_wire;
         repeat (BIT_CYC) @(posedge i_core_clk);
      end
   endtask
endmodule // swdp_dbg_model

// File: tb/swdp_top_bench.sv
// Self-checking bench for the single-wire debug port
`timescale 1ns/1ps
`include "swdp_map.svh"
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
   $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end

module swdp_top_bench;
   logic clk = 1'h0, rst_b = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0, ack = 1'h0, stopped = 1'h0;
   logic ev = 1'h0, crc = 1'h1, halt_seen = 1'h0, hv = 1'h0, err;
   logic [11:0] paddr = 12'h000, f;
   logic [31:0] pwdata = 32'h00000000, prdata, rd;
   logic [1:0] fuse = 2'h0;
   logic [7:0] rdata = 8'h00, flags = 8'hA5;
   logic pready, pslverr, pin_out, pin_oe, pull, inen, rfunc, req, we, halt, drv_low;
   logic [15:0] baddr;
   int errors = 0, cmp_count = 0;
   wire wire_lvl = (drv_low || (pin_oe && !pin_out)) ? 1'h0 : pull;

   swdp_top i_swdp_top (.i_core_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_reset_pin_function_fuse(fuse), .i_hv_override(hv), .i_pin_in(wire_lvl), .o_pin_out(pin_out),
      .o_pin_oe(pin_oe), .o_pin_pullup_en(pull), .o_pin_input_en(inen), .o_pin_reset_func_en(rfunc),
      .o_bus_req(req), .o_bus_we(we), .o_bus_addr(baddr), .o_bus_wdata(), .i_bus_ack(ack), .i_bus_rdata(rdata),
      .i_cpu_clk_stopped(stopped), .i_cpu_pc(16'h0000), .i_cpu_sp(16'h0000), .i_cpu_flags(flags),
      .i_crc_status(crc), .i_sleep_status(1'h0), .i_osc_event(ev), .o_cpu_run(), .o_cpu_halt(halt),
      .o_cpu_reset(), .o_cpu_step(), .o_bp_hit());
   swdp_dbg_model i_swdp_dbg_model (.i_core_clk(clk), .i_wire(wire_lvl), .o_drv_low(drv_low));

   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (halt === 1'h1) halt_seen <= 1'h1;
   end

   function automatic logic [11:0] fr(input logic [7:0] d);
      return {2'h3, ^d, d, 1'h0};
   endfunction

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'h1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'h1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      pen <= 1'h0;
   endtask

   task automatic sync_instr(input logic [7:0] ins);
      i_swdp_dbg_model.send(8'h55, 1'h0);
      i_swdp_dbg_model.send(ins, 1'h0);
   endtask

   task automatic t_pins();
      @(negedge clk);
      `CHK("reset_func", 1'h1, rfunc)
      @(posedge clk);
      fuse <= `SWDP_PINFUNC_PORT;
      repeat (4) @(posedge clk);
      @(negedge clk);
      `CHK("pullup", 3'h7, {pull, inen, ~rfunc})
      `CHK("oe_idle", 1'h0, pin_oe)
      @(posedge clk) hv <= 1'h1;
      @(posedge clk) hv <= 1'h0;
      fuse <= 2'h0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      `CHK("hv_pin", 3'h7, {pull, inen, ~rfunc})
      apb(1'h1, `SWDP_APB_STATUS, 32'hFFFFFFFF);
      apb(1'h0, `SWDP_APB_STATUS, 32'h0);
      `CHK("status", 32'h0000000F, rd)
      apb(1'h0, 12'h010, 32'h0);
      `CHK("unmapped", 33'h100000000, {err, rd})
      repeat (3) begin
         @(posedge clk) ev <= 1'h1;
         @(posedge clk) ev <= 1'h0;
      end
      apb(1'h0, `SWDP_APB_EVCNT, 32'h0);
      `CHK("evcnt", 32'h00000003, rd)
   endtask

   task automatic t_flags();
      sync_instr({`SWDP_OP_SYS_LD, 1'h0, `SWDP_SYS_FLAGS});
      i_swdp_dbg_model.recv(f);
      `CHK("flags", fr(8'hA5), f)
   endtask

   task automatic t_bus();
      int n;
      n = 0;
      stopped <= 1'h1;
      sync_instr({`SWDP_OP_BUS_RD, 5'h00});
      i_swdp_dbg_model.send(8'h34, 1'h0);
      i_swdp_dbg_model.send(8'h12, 1'h0);
      repeat (300) @(posedge clk);
      `CHK("req_stopped", 1'h0, req)
      stopped <= 1'h0;
      while (req !== 1'h1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      `CHK("bus_addr", 17'h02468, {baddr, we})
      repeat (20) @(posedge clk);
      ack <= 1'h1;
      rdata <= 8'h3C;
      @(posedge clk);
      ack <= 1'h0;
      i_swdp_dbg_model.recv(f);
      `CHK("bus_reply", fr(8'h3C), f)
   endtask

   task automatic t_halt();
      sync_instr({`SWDP_OP_SYS_ST, 1'h0, `SWDP_SYS_DBGCMD});
      i_swdp_dbg_model.send(8'h02, 1'h0);
      i_swdp_dbg_model.recv(f);
      `CHK("store_ack", fr(`SWDP_ACK_CHAR), f)
      `CHK("halt", 1'h1, halt_seen)
   endtask

   task automatic t_err();
      i_swdp_dbg_model.send(8'h55, 1'h0);
      i_swdp_dbg_model.send(8'h8C, 1'h1);
      apb(1'h0, `SWDP_APB_STATUS, 32'h0);
      `CHK("err_sig", 32'h0000002F, rd)
      apb(1'h0, `SWDP_APB_BAUD, 32'h0);
      `CHK("baud", 32'h00000001, rd)
      i_swdp_dbg_model.brk();
      sync_instr({`SWDP_OP_SYS_LD, 1'h0, `SWDP_SYS_STATUS});
      i_swdp_dbg_model.recv(f);
      `CHK("sys_status", fr(8'h12), f)
   endtask

   task automatic give_verdict();
      $display("Errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   initial begin
      repeat (100000) @(posedge clk);
      errors++;
      give_verdict();
   end

   initial begin
      repeat (2) @(posedge clk);
      rst_b <= 1'h1;
      t_pins();
      t_flags();
      t_bus();
      t_halt();
      t_err();
      give_verdict();
   end
endmodule // swdp_top_bench
